// ---- core/slms_pkg.sv ----
// Constants for the sync lock and mode select block
package slms_pkg;
	// Clock and switching rate limits
	localparam int CLK_KHZ           = 125000;
	localparam int FSW_MIN_KHZ       = 150;
	localparam int FSW_MAX_KHZ       = 1500;
	localparam int PER_MIN           = (CLK_KHZ + FSW_MAX_KHZ - 1) / FSW_MAX_KHZ;
	localparam int PER_MAX           = CLK_KHZ / FSW_MIN_KHZ;
	localparam int PER_TOL           = 2;
	// Lock time, as a count of switching periods
	localparam int LOCK_TIME_NS      = 130000;
	localparam int LOCK_FSW_KHZ      = 500;
	localparam int LOCK_PERIODS      = LOCK_TIME_NS * LOCK_FSW_KHZ / 1000000;
	localparam int SYNC_MISS_PERIODS = 13;
	// Mode reference bands, code 256 equals supply
	localparam int MODE_TH_LOW       = 29 * 256 / 100;
	localparam int MODE_TH_MID       = 45 * 256 / 100;
	localparam int MODE_TH_HIGH      = 62 * 256 / 100;
	localparam int INT_REF_MV        = 600;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_FREQ     = 8'h04;
	localparam logic [7:0] ADDR_STATUS   = 8'h08;
	localparam logic [7:0] ADDR_INT_ST   = 8'h0c;
	localparam logic [7:0] ADDR_INT_EN   = 8'h10;
	localparam logic [7:0] ADDR_INT_CLR  = 8'h14;
	localparam logic [7:0] ADDR_SYNC_PER = 8'h18;
	// Field positions and reset values
	localparam int CTRL_RUN_BIT      = 0;
	localparam int CTRL_SYNC_BIT     = 1;
	localparam int CTRL_CH2EN_BIT    = 2;
	localparam int IRQ_LOCK_BIT      = 0;
	localparam int IRQ_LOSS_BIT      = 1;
	localparam logic [2:0] CTRL_RST  = 3'h0;
	localparam logic [9:0] FREQ_RST  = 10'h0fa;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLV  = 2'h2;
	// Phase selections for channel 2
	localparam logic [1:0] PH_0      = 2'h0;
	localparam logic [1:0] PH_90     = 2'h1;
	localparam logic [1:0] PH_180    = 2'h2;
	typedef enum logic [1:0] {
		LK_IDLE   = 2'b00,
		LK_ACQ    = 2'b01,
		LK_LOCKED = 2'b10
	} slms_lock_t;
endpackage : slms_pkg

// ---- core/slms_sync2.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module slms_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;

	// First stage feeds only the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_ff <= '0;
			q       <= '0;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule : slms_sync2

// ---- core/slms_top.sv ----
// Switching clock supervisor with sync lock and mode select
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
// Notes on behaviour
// RULE_01: Fixed rate set between 150kHz and 1.5MHz
// RULE_02: Lock switching rate to external sync
// RULE_03: Phase clock rises at channel-1 clock fall
// RULE_04: Phase clock held off until lock
// RULE_05: Channel-1 enable released only after lock
// RULE_06: Lock acts on ch1 enable, ch2 soft-start
// RULE_07: Integrator ties all enable pins together
// RULE_08: Thirteen missed periods disable; relock soft-starts
// RULE_09: Sync held low keeps device disabled
// RULE_10: Reference level below 29% selects DDR
// RULE_11: Dual bands give 0, 90, 180 degrees
// RULE_12: Phase shift captured once at power-on
// RULE_13: DDR mode delays channel 1 60 degrees
// RULE_14: Low reference: ch2 uses lowest reference
// RULE_15: DDR shutdown: follow, then undervoltage protect
// RULE_16: Negative sense near supply tristates buffer
// RULE_17: Count periods without edge, clear on edge
// RULE_18: Mode register loads once after reset
module slms_top import slms_pkg::*; (
	input  wire logic       MCLK,
	input  wire logic       RST_N,
	input  wire logic       SYNC_CLOCK_INPUT,
	input  wire logic [7:0] MODE_REF_INPUT,
	input  wire logic       MODE_REF_INPUT_BELOW_800MV,
	input  wire logic       SENSE_NEG_NEAR_VCC,
	input  wire logic       CH1_BELOW_87,
	input  wire logic       CH2_BELOW_87,
	input  wire logic [9:0] TRACK_LEVEL_MV,
	input  wire logic [9:0] SS_LEVEL_MV,
	output logic            PHASE_CLOCK_OUT,
	output logic            CH1_PWM_CLK,
	output logic            CH2_PWM_CLK,
	output logic            CH1_ENABLE_FEEDFORWARD,
	output logic            CH2_ENABLE_FEEDFORWARD,
	output logic            CH2_SS_RESTART,
	output logic [9:0]      CH2_REF_LEVEL_MV,
	output logic            CH2_FOLLOW_CH1,
	output logic            UV_PROTECT,
	output logic            SENSE_BUF_OE,
	output logic            IRQ,
	input  wire logic [7:0] S_AXI_AWADDR,
	input  wire logic       S_AXI_AWVALID,
	output logic            S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0] S_AXI_WSTRB,
	input  wire logic       S_AXI_WVALID,
	output logic            S_AXI_WREADY,
	output logic [1:0]      S_AXI_BRESP,
	output logic            S_AXI_BVALID,
	input  wire logic       S_AXI_BREADY,
	input  wire logic [7:0] S_AXI_ARADDR,
	input  wire logic       S_AXI_ARVALID,
	output logic            S_AXI_ARREADY,
	output logic [31:0]     S_AXI_RDATA,
	output logic [1:0]      S_AXI_RRESP,
	output logic            S_AXI_RVALID,
	input  wire logic       S_AXI_RREADY
);
	localparam logic [9:0] P_MIN  = 10'(PER_MIN);
	localparam logic [9:0] P_MAX  = 10'(PER_MAX);
	localparam logic [9:0] P_TOL  = 10'(PER_TOL);
	localparam logic [6:0] LK_N   = 7'(LOCK_PERIODS);
	localparam logic [3:0] MISS_N = 4'(SYNC_MISS_PERIODS);
	localparam logic [9:0] REF_MV = 10'(INT_REF_MV);

	// Synchronised pin levels
	logic [32:0] pin_s;
	logic        sync_s, mode_ref_input_low_s, sense_near_s, ch1_low_s, ch2_low_s;
	logic [7:0]  mode_code_s;
	logic [9:0]  track_s, ss_s;

	slms_sync2 #(.W(33)) u_sync (
		.clk   (MCLK),
		.rst_n (RST_N),
		.d     ({SYNC_CLOCK_INPUT, MODE_REF_INPUT, MODE_REF_INPUT_BELOW_800MV,
		         SENSE_NEG_NEAR_VCC, CH1_BELOW_87, CH2_BELOW_87,
		         TRACK_LEVEL_MV, SS_LEVEL_MV}),
		.q     (pin_s)
	);
	assign {sync_s, mode_code_s, mode_ref_input_low_s, sense_near_s, ch1_low_s,
	        ch2_low_s, track_s, ss_s} = pin_s;

	// Register state
	logic [2:0]  ctrl_ff, nxt_ctrl;
	logic [9:0]  freq_ff, nxt_freq;
	logic [1:0]  irq_st_ff, nxt_irq_st, irq_enable_feedforward_pin, nxt_irq_en;
	// Mode and analog group
	logic [1:0]  cap_cnt_ff, nxt_cap_cnt;
	logic        ddr_ff, nxt_ddr;
	logic [1:0]  phase_ff, nxt_phase;
	logic [9:0]  ref_ff, nxt_ref;
	logic        follow_ff, nxt_follow, uv_ff, nxt_uv, oe_ff, nxt_oe;
	logic        ch2en_ff, nxt_ch2en;
	// Timing and lock group
	slms_lock_t  lk_st_ff, nxt_lk_st;
	logic [9:0]  cnt_ff, nxt_cnt, per_ff, nxt_per;
	logic [9:0]  meas_ff, nxt_meas, last_ff, nxt_last, mper_ff, nxt_mper;
	logic [6:0]  match_ff, nxt_match;
	logic [3:0]  miss_ff, nxt_miss;
	logic        sync_d_ff, lost_ff, nxt_lost;
	logic        ch1clk_ff, nxt_ch1clk, ch2clk_ff, nxt_ch2clk;
	logic        phclk_ff, nxt_phclk, gate_ff, nxt_gate;
	logic        ch1en_ff, nxt_ch1en, ss_ff, nxt_ss;
	logic        rise, sync_mode, pll_ok, per_end, lock_evt, loss_evt;
	logic [9:0]  per_fix, diff, ch1_off, ch2_off;
	// Bus group
	logic        aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
	logic [7:0]  awaddr_ff, nxt_awaddr;
	logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
	logic [3:0]  wstrb_ff, nxt_wstrb;
	logic        awrdy_ff, nxt_awrdy, wrdy_ff, nxt_wrdy, arrdy_ff, nxt_arrdy;
	logic        bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid, irq_ff, nxt_irq;
	logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;

	// Position of a shifted channel within the period
	function automatic logic chan_high(input logic [9:0] c, input logic [9:0] p,
	                                   input logic [9:0] off);
		logic [10:0] pos;
		pos = (c >= off) ? {1'b0, c - off} : 11'({1'b0, c} + {1'b0, p} - {1'b0, off});
		return pos < {2'b00, p[9:1]};
	endfunction : chan_high

	// Byte-lane merge of a write
	function automatic logic [31:0] merge(input logic [31:0] old,
	                                      input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) r[8*i +: 8] = d[8*i +: 8];
		end
		return r;
	endfunction : merge

	// Mode capture and analog supervision, next values
	always_comb begin
		nxt_cap_cnt = cap_cnt_ff;
		nxt_ddr     = ddr_ff;
		nxt_phase   = phase_ff;
		if (cap_cnt_ff != 2'h3) begin // RULE_18
			nxt_cap_cnt = cap_cnt_ff + 2'h1;
		end
		if (cap_cnt_ff == 2'h2) begin // RULE_12
			nxt_ddr   = mode_code_s < 8'(MODE_TH_LOW); // RULE_10
			if (mode_code_s < 8'(MODE_TH_MID)) nxt_phase = PH_0; // RULE_11
			else if (mode_code_s < 8'(MODE_TH_HIGH)) nxt_phase = PH_90;
			else nxt_phase = PH_180;
		end
		// Lowest of the candidate references
		nxt_ref = (ss_s < REF_MV) ? ss_s : REF_MV;
		if (mode_ref_input_low_s && track_s < nxt_ref) nxt_ref = track_s; // RULE_14
		nxt_follow = ddr_ff && !ch1en_ff && !(ch1_low_s && ch2_low_s); // RULE_15
		nxt_uv     = ddr_ff && !ch1en_ff && ch1_low_s && ch2_low_s; // RULE_15
		nxt_oe     = !sense_near_s; // RULE_16
		nxt_ch2en  = ctrl_ff[CTRL_CH2EN_BIT]; // RULE_06
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			cap_cnt_ff <= 2'h0;
			ddr_ff     <= 1'b0;
			phase_ff   <= PH_0;
			ref_ff     <= 10'h000;
			follow_ff  <= 1'b0;
			uv_ff      <= 1'b0;
			oe_ff      <= 1'b0;
			ch2en_ff   <= 1'b0;
		end else begin
			cap_cnt_ff <= nxt_cap_cnt;
			ddr_ff     <= nxt_ddr;
			phase_ff   <= nxt_phase;
			ref_ff     <= nxt_ref;
			follow_ff  <= nxt_follow;
			uv_ff      <= nxt_uv;
			oe_ff      <= nxt_oe;
			ch2en_ff   <= nxt_ch2en;
		end
	end

	// Switching timebase and lock supervisor, next values
	always_comb begin
		rise      = sync_s && !sync_d_ff;
		sync_mode = ctrl_ff[CTRL_SYNC_BIT];
		per_fix   = (freq_ff < P_MIN) ? P_MIN : (freq_ff > P_MAX) ? P_MAX : freq_ff; // RULE_01
		diff      = (meas_ff > last_ff) ? meas_ff - last_ff : last_ff - meas_ff;
		per_end   = cnt_ff >= per_ff - 10'h001;
		nxt_lk_st = lk_st_ff;
		nxt_match = match_ff;
		nxt_last  = last_ff;
		nxt_mper  = mper_ff;
		lock_evt  = 1'b0;
		nxt_per   = (sync_mode && lk_st_ff == LK_LOCKED) ? mper_ff : per_fix; // RULE_02
		nxt_cnt   = per_end ? 10'h000 : cnt_ff + 10'h001;
		if (lk_st_ff == LK_LOCKED && rise) nxt_cnt = 10'h000; // RULE_02
		nxt_meas  = rise ? 10'h001 : (meas_ff == 10'h3ff) ? meas_ff : meas_ff + 10'h001;
		if (rise) nxt_miss = 4'h0; // RULE_17
		else if (per_end && miss_ff < MISS_N) nxt_miss = miss_ff + 4'h1; // RULE_17
		else nxt_miss = miss_ff;
		if (!sync_mode) begin
			nxt_lk_st = LK_IDLE;
			nxt_match = 7'h00;
		end else begin
			unique case (lk_st_ff)
				LK_IDLE: nxt_lk_st = LK_ACQ;
				LK_ACQ: if (rise) begin
					nxt_last = meas_ff;
					if (meas_ff >= P_MIN && meas_ff <= P_MAX && diff <= P_TOL) begin
						nxt_match = match_ff + 7'h01;
						if (nxt_match >= LK_N) begin
							nxt_lk_st = LK_LOCKED;
							nxt_mper  = meas_ff;
							lock_evt  = 1'b1;
						end
					end else begin
						nxt_match = 7'h00;
					end
				end
				LK_LOCKED: begin
					if (rise && meas_ff >= P_MIN && meas_ff <= P_MAX) nxt_mper = meas_ff;
					if (miss_ff >= MISS_N || (rise && (meas_ff < P_MIN || meas_ff > P_MAX))) begin
						nxt_lk_st = LK_ACQ; // RULE_08
						nxt_match = 7'h00;
					end
				end
				default: nxt_lk_st = LK_IDLE;
			endcase
		end
		// Loss flag, set on thirteen missing periods, cleared by lock
		loss_evt = sync_mode && miss_ff >= MISS_N && !lost_ff; // RULE_09
		nxt_lost = sync_mode && !lock_evt && (lost_ff || miss_ff >= MISS_N);
		pll_ok   = !sync_mode || lk_st_ff == LK_LOCKED;
		nxt_gate  = pll_ok;
		nxt_ch1en = ctrl_ff[CTRL_RUN_BIT] && pll_ok; // RULE_05
		nxt_ss    = lk_st_ff != LK_LOCKED && nxt_lk_st == LK_LOCKED; // RULE_08
		// Channel offsets
		ch1_off = ddr_ff ? per_ff / 10'h006 : 10'h000; // RULE_13
		if (ddr_ff || phase_ff == PH_0) ch2_off = 10'h000;
		else if (phase_ff == PH_90) ch2_off = {2'b00, per_ff[9:2]};
		else ch2_off = {1'b0, per_ff[9:1]};
		nxt_ch1clk = chan_high(cnt_ff, per_ff, ch1_off);
		nxt_ch2clk = chan_high(cnt_ff, per_ff, ch2_off);
		nxt_phclk  = pll_ok && !nxt_ch1clk; // RULE_03 RULE_04
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			lk_st_ff  <= LK_IDLE;
			cnt_ff    <= 10'h000;
			per_ff    <= FREQ_RST;
			meas_ff   <= 10'h000;
			last_ff   <= 10'h000;
			mper_ff   <= FREQ_RST;
			match_ff  <= 7'h00;
			miss_ff   <= 4'h0;
			sync_d_ff <= 1'b0;
			lost_ff   <= 1'b0;
			ch1clk_ff <= 1'b0;
			ch2clk_ff <= 1'b0;
			phclk_ff  <= 1'b0;
			gate_ff   <= 1'b0;
			ch1en_ff  <= 1'b0;
			ss_ff     <= 1'b0;
		end else begin
			lk_st_ff  <= nxt_lk_st;
			cnt_ff    <= nxt_cnt;
			per_ff    <= nxt_per;
			meas_ff   <= nxt_meas;
			last_ff   <= nxt_last;
			mper_ff   <= nxt_mper;
			match_ff  <= nxt_match;
			miss_ff   <= nxt_miss;
			sync_d_ff <= sync_s;
			lost_ff   <= nxt_lost;
			ch1clk_ff <= nxt_ch1clk;
			ch2clk_ff <= nxt_ch2clk;
			phclk_ff  <= nxt_phclk;
			gate_ff   <= nxt_gate;
			ch1en_ff  <= nxt_ch1en;
			ss_ff     <= nxt_ss;
		end
	end

	// Bus slave and interrupt registers, next values
	always_comb begin
		logic [31:0] wv, mv;
		wv          = merge(32'h0, wdata_ff, wstrb_ff);
		mv          = 32'h0;
		nxt_aw_got  = aw_got_ff;
		nxt_awaddr  = awaddr_ff;
		nxt_w_got   = w_got_ff;
		nxt_wdata   = wdata_ff;
		nxt_wstrb   = wstrb_ff;
		nxt_bvalid  = bvalid_ff && !S_AXI_BREADY;
		nxt_bresp   = bresp_ff;
		nxt_ctrl    = ctrl_ff;
		nxt_freq    = freq_ff;
		nxt_irq_en  = irq_enable_feedforward_pin;
		nxt_irq_st  = irq_st_ff;
		nxt_rvalid  = rvalid_ff && !S_AXI_RREADY;
		nxt_rdata   = rdata_ff;
		nxt_rresp   = rresp_ff;
		if (S_AXI_AWVALID && awrdy_ff) begin
			nxt_aw_got = 1'b1;
			nxt_awaddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && wrdy_ff) begin
			nxt_w_got = 1'b1;
			nxt_wdata = S_AXI_WDATA;
			nxt_wstrb = S_AXI_WSTRB;
		end
		// Perform the write once address and data are both held
		if (aw_got_ff && w_got_ff && !bvalid_ff) begin
			nxt_aw_got = 1'b0;
			nxt_w_got  = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp  = RESP_OKAY;
			unique case (awaddr_ff)
				ADDR_CTRL: begin
					mv       = merge({29'h0, ctrl_ff}, wdata_ff, wstrb_ff);
					nxt_ctrl = mv[2:0];
				end
				ADDR_FREQ: begin
					mv       = merge({22'h0, freq_ff}, wdata_ff, wstrb_ff);
					nxt_freq = mv[9:0];
				end
				ADDR_INT_EN: begin
					mv         = merge({30'h0, irq_enable_feedforward_pin}, wdata_ff, wstrb_ff);
					nxt_irq_en = mv[1:0];
				end
				ADDR_INT_CLR: nxt_irq_st = irq_st_ff & ~wv[1:0];
				ADDR_STATUS, ADDR_INT_ST, ADDR_SYNC_PER: nxt_bresp = RESP_OKAY;
				default:     nxt_bresp  = RESP_SLV;
			endcase
		end
		// Events set sticky bits, winning over a clear
		nxt_irq_st[IRQ_LOCK_BIT] = nxt_irq_st[IRQ_LOCK_BIT] | lock_evt;
		nxt_irq_st[IRQ_LOSS_BIT] = nxt_irq_st[IRQ_LOSS_BIT] | loss_evt;
		if (S_AXI_ARVALID && arrdy_ff) begin
			nxt_rvalid = 1'b1;
			nxt_rresp  = RESP_OKAY;
			unique case (S_AXI_ARADDR)
				ADDR_CTRL:     nxt_rdata = {29'h0, ctrl_ff};
				ADDR_FREQ:     nxt_rdata = {22'h0, freq_ff};
				ADDR_STATUS:   nxt_rdata = {24'h0, ss_ff, ch1en_ff, phase_ff,
				                            ddr_ff, lost_ff, lk_st_ff};
				ADDR_INT_ST:   nxt_rdata = {30'h0, irq_st_ff};
				ADDR_INT_EN:   nxt_rdata = {30'h0, irq_enable_feedforward_pin};
				ADDR_INT_CLR:  nxt_rdata = 32'h0;
				ADDR_SYNC_PER: nxt_rdata = {22'h0, mper_ff};
				default: begin
					nxt_rdata = 32'h0;
					nxt_rresp = RESP_SLV;
				end
			endcase
		end
		nxt_awrdy = !nxt_aw_got && !nxt_bvalid;
		nxt_wrdy  = !nxt_w_got && !nxt_bvalid;
		nxt_arrdy = !nxt_rvalid;
		nxt_irq   = |(nxt_irq_st & nxt_irq_en);
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			aw_got_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			w_got_ff  <= 1'b0;
			wdata_ff  <= 32'h0;
			wstrb_ff  <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0;
			rresp_ff  <= RESP_OKAY;
			awrdy_ff  <= 1'b0;
			wrdy_ff   <= 1'b0;
			arrdy_ff  <= 1'b0;
			ctrl_ff   <= CTRL_RST;
			freq_ff   <= FREQ_RST;
			irq_enable_feedforward_pin <= 2'h0;
			irq_st_ff <= 2'h0;
			irq_ff    <= 1'b0;
		end else begin
			aw_got_ff <= nxt_aw_got;
			awaddr_ff <= nxt_awaddr;
			w_got_ff  <= nxt_w_got;
			wdata_ff  <= nxt_wdata;
			wstrb_ff  <= nxt_wstrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff  <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rdata_ff  <= nxt_rdata;
			rresp_ff  <= nxt_rresp;
			awrdy_ff  <= nxt_awrdy;
			wrdy_ff   <= nxt_wrdy;
			arrdy_ff  <= nxt_arrdy;
			ctrl_ff   <= nxt_ctrl;
			freq_ff   <= nxt_freq;
			irq_enable_feedforward_pin <= nxt_irq_en;
			irq_st_ff <= nxt_irq_st;
			irq_ff    <= nxt_irq;
		end
	end

	// Output connections
	assign PHASE_CLOCK_OUT        = phclk_ff;
	assign CH1_PWM_CLK            = ch1clk_ff;
	assign CH2_PWM_CLK            = ch2clk_ff;
	assign CH1_ENABLE_FEEDFORWARD = ch1en_ff;
	assign CH2_ENABLE_FEEDFORWARD = ch2en_ff;
	assign CH2_SS_RESTART         = ss_ff;
	assign CH2_REF_LEVEL_MV       = ref_ff;
	assign CH2_FOLLOW_CH1         = follow_ff;
	assign UV_PROTECT             = uv_ff;
	assign SENSE_BUF_OE           = oe_ff;
	assign IRQ                    = irq_ff;
	assign S_AXI_AWREADY          = awrdy_ff;
	assign S_AXI_WREADY           = wrdy_ff;
	assign S_AXI_BRESP            = bresp_ff;
	assign S_AXI_BVALID           = bvalid_ff;
	assign S_AXI_ARREADY          = arrdy_ff;
	assign S_AXI_RDATA            = rdata_ff;
	assign S_AXI_RRESP            = rresp_ff;
	assign S_AXI_RVALID           = rvalid_ff;

	// Checks on the supervisor behaviour
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	sequence s_edge_missing;
		sync_mode && miss_ff >= MISS_N;
	endsequence
	sequence s_ch1_off;
		!CH1_ENABLE_FEEDFORWARD;
	endsequence

	AST_FREQ_RANGE: assert property ( // RULE_01
		##1 per_ff >= P_MIN && per_ff <= P_MAX)
		else $error("switching period out of range");
	AST_SYNC_ALIGN: assert property ( // RULE_02
		lk_st_ff == LK_LOCKED && rise && sync_mode |=> cnt_ff == 10'h000)
		else $error("counter not aligned to sync edge");
	AST_LEAD_EDGE: assert property ( // RULE_03
		$rose(PHASE_CLOCK_OUT) && $past(gate_ff) |-> $fell(CH1_PWM_CLK))
		else $error("phase clock edge not at ch1 fall");
	AST_PHASE_GATED: assert property ( // RULE_04
		sync_mode && lk_st_ff != LK_LOCKED |=> !PHASE_CLOCK_OUT)
		else $error("phase clock out before lock");
	AST_CH1_HOLD: assert property ( // RULE_05
		sync_mode && lk_st_ff != LK_LOCKED |=> s_ch1_off)
		else $error("ch1 enabled before lock");
	AST_CH2_FREE: assert property ( // RULE_06
		ctrl_ff[CTRL_CH2EN_BIT] |=> CH2_ENABLE_FEEDFORWARD)
		else $error("ch2 enable gated by lock");
	AST_LOSS_DISABLE: assert property ( // RULE_08
		s_edge_missing ##1 ctrl_ff[CTRL_SYNC_BIT] |=> s_ch1_off)
		else $error("not disabled after sync loss");
	AST_RELOCK_SS: assert property ( // RULE_08
		lock_evt |=> CH2_SS_RESTART ##1 !CH2_SS_RESTART)
		else $error("no soft-start pulse on relock");
	AST_MISS_CLEAR: assert property ( // RULE_17
		rise |=> miss_ff == 4'h0)
		else $error("miss count not cleared by edge");
	AST_MODE_HELD: assert property ( // RULE_12
		cap_cnt_ff == 2'h3 |=> $stable(ddr_ff) && $stable(phase_ff))
		else $error("mode changed after capture");
	AST_DDR_DECODE: assert property ( // RULE_10
		cap_cnt_ff == 2'h2 && mode_code_s < 8'(MODE_TH_LOW) |=> ddr_ff)
		else $error("low reference not decoded as DDR");
	AST_REF_MIN: assert property ( // RULE_14
		mode_ref_input_low_s |=> CH2_REF_LEVEL_MV <= REF_MV
		&& CH2_REF_LEVEL_MV <= $past(track_s) && CH2_REF_LEVEL_MV <= $past(ss_s))
		else $error("ch2 reference not lowest");
	AST_SENSE_OE: assert property ( // RULE_16
		sense_near_s |=> !SENSE_BUF_OE)
		else $error("sense buffer driven near supply");
endmodule : slms_top

// ---- test/slms_sync_src.sv ----
// Behavioural external sync source for the bench
`timescale 1ns/10ps
module slms_sync_src #(
	parameter int HALF_NS = 1000
) (
	input  wire logic en,
	output logic      sync
);
	// Square wave while enabled, held low otherwise
	initial begin
		sync = 1'b0;
		forever begin
			#HALF_NS;
			sync = en ? ~sync : 1'b0;
		end
	end
endmodule : slms_sync_src

// ---- test/testbench.sv ----
// Self-checking bench for the sync lock and mode select block
`timescale 1ns/10ps
module testbench import slms_pkg::*;;
	logic        mclk, rst_n, sen, sync, rlo, shi, c1b, c2b, smode, q;
	logic        awv, wv, bry, arv, rry, awr, wrr, arr, bv, rv;
	logic        ph, c1c, c2c, c1e, c2e, ssr, fol, uv, oe, irq;
	logic [7:0]  mref, awa, ara, lo[4], hi[4];
	logic [31:0] wd, rdt;
	logic [9:0]  trk, ss, ref2, ex;
	logic [1:0]  br, rr;
	logic [3:0]  ws;
	logic [65:0] e;
	logic [65:0] rq[$];
	logic [1:0]  bq[$];
	int          miscompares, n_compared, cyc, n, ssn, s0, badph;
	slms_top slms_top_i (.MCLK(mclk), .RST_N(rst_n), .SYNC_CLOCK_INPUT(sync),
		.MODE_REF_INPUT(mref), .MODE_REF_INPUT_BELOW_800MV(rlo),
		.SENSE_NEG_NEAR_VCC(shi), .CH1_BELOW_87(c1b), .CH2_BELOW_87(c2b),
		.TRACK_LEVEL_MV(trk), .SS_LEVEL_MV(ss), .PHASE_CLOCK_OUT(ph),
		.CH1_PWM_CLK(c1c), .CH2_PWM_CLK(c2c), .CH1_ENABLE_FEEDFORWARD(c1e),
		.CH2_ENABLE_FEEDFORWARD(c2e), .CH2_SS_RESTART(ssr),
		.CH2_REF_LEVEL_MV(ref2), .CH2_FOLLOW_CH1(fol), .UV_PROTECT(uv),
		.SENSE_BUF_OE(oe), .IRQ(irq), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(wrr), .S_AXI_BRESP(br),
		.S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt),
		.S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry));
	slms_sync_src slms_sync_src_i (.en(sen), .sync(sync));
	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic clk(input int k);
		repeat (k) @(posedge mclk);
	endtask : clk
	task automatic rst;
		rst_n <= 1'b0;
		clk(3);
		rst_n <= 1'b1;
		clk(5);
	endtask : rst
	// Write cycle, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] r);
		bq.push_back(r);
		awa <= a;
		wd  <= d;
		awv <= 1'b1;
		wv  <= 1'b1;
		bry <= 1'b1;
		do begin
			@(posedge mclk);
			if (awr === 1'b1) awv <= 1'b0;
			if (wrr === 1'b1) wv <= 1'b0;
		end while (bv !== 1'b1);
		bry <= 1'b0;
		clk(1);
	endtask : wr
	// Read cycle, expected data under a mask
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
			input logic [31:0] m, input logic [1:0] r);
		rq.push_back({r, m, d});
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do begin
			@(posedge mclk);
			if (arr === 1'b1) arv <= 1'b0;
		end while (rv !== 1'b1);
		rry <= 1'b0;
		clk(1);
	endtask : rd
	// Wait for channel 1 enable to reach a level
	task automatic wt(input logic v, input int lim);
		n = 0;
		while (c1e !== v && n < lim) begin
			clk(1);
			n++;
		end
	endtask : wt
	// Period of the channel 1 clock in cycles
	task automatic meas(output int p);
		int k;
		logic pv;
		pv = 1'b1;
		k = 0;
		p = 0;
		while (k < 2 && p < 4000) begin
			@(posedge mclk);
			#1;
			p++;
			if (pv === 1'b0 && c1c === 1'b1) begin
				k++;
				if (k == 1) p = 0;
			end
			pv = c1c;
		end
		@(posedge mclk);
	endtask : meas
	// Clock and timeout
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 95000) begin
			miscompares++;
			end_sim();
		end
	end
	// Response watcher and lock side effects
	always @(posedge mclk) begin
		if (rv === 1'b1 && rry === 1'b1 && rq.size() > 0) begin
			e = rq.pop_front();
			chk(rdt & e[63:32], e[31:0]);
			chk({30'h0, rr}, {30'h0, e[65:64]});
		end
		if (bv === 1'b1 && bry === 1'b1 && bq.size() > 0)
			chk({30'h0, br}, {30'h0, bq.pop_front()});
		if (ssr === 1'b1) ssn++;
		if (smode && c1e !== 1'b1 && q !== 1'b1 && ph === 1'b1) badph++;
		q <= c1e;
	end
	initial begin
		{rst_n, sen, rlo, shi, c1b, c2b, smode, awv, wv, bry, arv, rry} = '0;
		{mref, awa, ara, wd, trk, ss} = '0;
		ws = 4'hf;
		lo = '{8'h00, 8'h4a, 8'h73, 8'h9e};
		hi = '{8'h49, 8'h72, 8'h9d, 8'hff};
		void'($urandom(32'hacd3804a));
		// Mode and phase decoded once per power-on
		for (int i = 0; i < 4; i++) begin
			mref <= lo[i] + 8'($urandom % (hi[i] - lo[i] + 9'h1));
			rst();
			ex = (i == 0) ? 10'h8 : {4'h0, 2'(i - 1), 4'h0};
			rd(ADDR_STATUS, 32'(ex), i ? 32'h38 : 32'h8, RESP_OKAY);
			mref <= ~mref;
			clk(5);
			rd(ADDR_STATUS, 32'(ex), i ? 32'h38 : 32'h8, RESP_OKAY);
			if (i == 0) begin
				// Channel 1 lags channel 2 by a sixth of the period
				@(posedge c2c);
				s0 = int'($time);
				@(posedge c1c);
				n = (int'($time) - s0) / 8;
				chk(n, 32'(FREQ_RST * 60 / 360));
				c2b <= 1'b1;
				clk(6);
				chk(fol, 1'b1);
				c1b <= 1'b1;
				clk(6);
				chk(uv, 1'b1);
			end
		end
		$display("mode test done");
		rd(8'h1c, 32'h0, 32'hffffffff, RESP_SLV);
		wr(8'h1c, 32'h1, RESP_SLV);
		// Fixed rate at both ends of the range
		wr(ADDR_CTRL, 32'h1, RESP_OKAY);
		foreach (lo[k]) if (k < 2) begin
			wr(ADDR_FREQ, k ? 32'd833 : 32'd84, RESP_OKAY);
			meas(n);
			chk(n, k ? 32'd833 : 32'd84);
			if (k == 0) begin
				chk(c2c, !c1c);
				chk(ph, !c1c);
			end
		end
		// Single byte lane write keeps the upper byte
		ws <= 4'h1;
		wr(ADDR_FREQ, 32'h20, RESP_OKAY);
		ws <= 4'hf;
		rd(ADDR_FREQ, 32'h320, 32'hffffffff, RESP_OKAY);
		$display("fixed rate test done");
		// Lock to a 500 kHz sync source
		wr(ADDR_CTRL, 32'h3, RESP_OKAY);
		wr(ADDR_INT_EN, 32'h3, RESP_OKAY);
		smode = 1'b1;
		sen <= 1'b1;
		wt(1'b1, 25000);
		chk(n >= 16000, 1'b1);
		chk(ssn, 1);
		chk(badph, 0);
		rd(ADDR_STATUS, 32'h2, 32'h3, RESP_OKAY);
		rd(ADDR_SYNC_PER, 32'd250, 32'h3ff, RESP_OKAY);
		chk(irq, 1'b1);
		wr(ADDR_INT_CLR, 32'h3, RESP_OKAY);
		clk(3);
		chk(irq, 1'b0);
		$display("lock test done");
		// Sync held low, then relock
		sen <= 1'b0;
		wt(1'b0, 5000);
		chk(n >= 2900 && n <= 3300, 1'b1);
		wr(ADDR_CTRL, 32'h7, RESP_OKAY);
		clk(3);
		chk(c2e, 1'b1);
		chk(c1e, 1'b0);
		rd(ADDR_INT_ST, 32'h2, 32'h2, RESP_OKAY);
		chk(irq, 1'b1);
		wr(ADDR_INT_CLR, 32'h3, RESP_OKAY);
		s0 = ssn;
		sen <= 1'b1;
		wt(1'b1, 25000);
		chk(c1e, 1'b1);
		chk(ssn, s0 + 1);
		chk(badph, 0);
		$display("loss test done");
		// Channel 2 reference and sense buffer
		repeat (4) begin
			ss  <= 10'($urandom);
			trk <= 10'($urandom);
			rlo <= 1'($urandom);
			clk(6);
			ex = (ss < 10'd600) ? ss : 10'd600;
			if (rlo && trk < ex) ex = trk;
			chk({22'h0, ref2}, {22'h0, ex});
		end
		shi <= 1'b1;
		clk(6);
		chk(oe, 1'b0);
		shi <= 1'b0;
		clk(6);
		chk(oe, 1'b1);
		$display("reference test done");
		end_sim();
	end
endmodule : testbench
